// file: design/iqr_pkg.sv
// ==========================================================
// Register map, field layout and response layout
package iqr_pkg;
	// Register byte addresses
	localparam logic [7:0]  ADDR_CFG0     = 8'h00;
	localparam logic [7:0]  ADDR_CFG1     = 8'h04;
	localparam logic [7:0]  ADDR_VSLEN    = 8'h08;
	localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
	localparam logic [7:0]  ADDR_ASCII0   = 8'h10;
	localparam logic [7:0]  ADDR_ASCII6   = 8'h28;
	localparam int          ASCII_WORDS   = 7;
	// Write masks (reserved bits read as zero) and reset values
	localparam logic [31:0] CFG0_MASK     = 32'h0000_01FF;
	localparam logic [31:0] CFG1_MASK     = 32'hFB03_FFFF;
	localparam logic [31:0] CFG0_RESET    = 32'h0000_001F;
	localparam logic [31:0] CFG1_RESET    = 32'h0000_0200;
	localparam logic [31:0] ASCII_RESET   = 32'h2020_2020;
	// CFG0 fields
	localparam int          F_TYPE        = 0;
	localparam int          F_QUAL        = 5;
	localparam int          F_UNSUPP      = 8;
	// CFG1 fields
	localparam int          F_REMOVABLE   = 0;
	localparam int          F_MODIFIER    = 1;
	localparam int          F_NATVER      = 8;
	localparam int          F_INTLVER_B   = 11;
	localparam int          F_INTLVER_A   = 14;
	localparam int          F_ASYNC_NTFY  = 16;
	localparam int          F_TERM_MSG    = 17;
	localparam int          F_FLAGS7      = 24;
	// Byte-0, byte-2 and byte-3 codes
	localparam logic [7:0]  BYTE0_NO_LUN  = 8'h7F;
	localparam logic [2:0]  QUAL_PRESENT  = 3'h0;
	localparam logic [2:0]  QUAL_RSVD     = 3'h2;
	localparam logic [2:0]  QUAL_NO_LUN   = 3'h3;
	localparam logic [4:0]  TYPE_LAST_STD = 5'h0B;
	localparam logic [4:0]  TYPE_NONE     = 5'h1F;
	localparam logic [4:0]  TYPE_PROC     = 5'h03;
	localparam logic [2:0]  NATVER_MAX    = 3'h2;
	localparam logic [3:0]  RESP_FORMAT   = 4'h2;
	// Response layout
	localparam logic [6:0]  MANDATORY_LEN = 7'h24;
	localparam logic [6:0]  ASCII_FIRST   = 7'h08;
	localparam logic [6:0]  ASCII_END     = 7'h24;
	localparam logic [5:0]  EXTRA_MAX     = 6'h3C;
	localparam logic [6:0]  LEN_HDR       = 7'h05;
	localparam logic [7:0]  ASCII_SPACE   = 8'h20;
	localparam logic [7:0]  ASCII_TILDE   = 8'h7E;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// True for a printable graphic code
	function automatic logic is_graphic(input logic [7:0] b);
		return (b >= ASCII_SPACE) && (b <= ASCII_TILDE);
	endfunction : is_graphic

	// Merge write data into a register under byte strobes and a mask
	function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r & mask;
	endfunction : merge_word
endpackage : iqr_pkg

// file: design/iqr_ascii_field.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Left-aligned ASCII field cleanup: a 00h byte ends the text, every byte from there on
// becomes a space, and any other non-printable byte is replaced by a space.
module iqr_ascii_field #(
	parameter int N = 8
) (
	input  wire logic [N*8-1:0] raw,    // Field bytes, offset 0 in low bits
	output logic      [N*8-1:0] clean   // Printable, space padded
);
	import iqr_pkg::*;

	// Scan from lowest offset so padding ends up at the highest offsets
	always_comb begin
		logic ended;
		ended = 1'b0;
		clean = '0;
		for (int i = 0; i < N; i++) begin
			if (raw[8*i +: 8] == 8'h00) begin
				ended = 1'b1;
			end
			if (ended || !is_graphic(raw[8*i +: 8])) begin
				clean[8*i +: 8] = ASCII_SPACE;
			end else begin
				clean[8*i +: 8] = raw[8*i +: 8];
			end
		end
	end
endmodule : iqr_ascii_field
`default_nettype wire

// file: design/iqr_builder.sv
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Standard identification response builder with AXI4-Lite configuration
module iqr_builder (
	input  wire logic        core_clk,       // System clock, 100 MHz
	input  wire logic        rst_n,          // Asynchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // Write address
	input  wire logic        s_axi_awvalid,  // Write address valid
	output logic             s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
	input  wire logic        s_axi_wvalid,   // Write data valid
	output logic             s_axi_wready,   // Write data ready
	output logic [1:0]       s_axi_bresp,    // Write response
	output logic             s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [7:0]  s_axi_araddr,   // Read address
	input  wire logic        s_axi_arvalid,  // Read address valid
	output logic             s_axi_arready,  // Read address ready
	output logic [31:0]      s_axi_rdata,    // Read data
	output logic [1:0]       s_axi_rresp,    // Read response
	output logic             s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	input  wire logic        cmd_valid,      // Request for the response
	input  wire logic [7:0]  cmd_alloc_len,  // Allocation length in bytes
	output logic             cmd_ready,      // Idle, request accepted
	output logic             data_valid,     // Response byte valid
	output logic [7:0]       data_byte,      // Response byte
	output logic             data_last,      // Last byte of the transfer
	input  wire logic        data_ready,     // Initiator side takes byte
	output logic             cmd_done        // One-cycle end of transfer
);
	import iqr_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         aw_got;
		logic                         w_got;
		logic [7:0]                   aw_addr;
		logic [31:0]                  w_data;
		logic [3:0]                   w_strb;
		logic                         arready;
		logic                         rvalid;
		logic [1:0]                   rresp;
		logic [31:0]                  rdata;
		logic [31:0]                  cfg0;
		logic [31:0]                  cfg1;
		logic [5:0]                   extra;
		logic [ASCII_WORDS-1:0][31:0] ascii;
		logic                         busy;
		logic                         cmd_ready;
		logic                         data_valid;
		logic                         data_last;
		logic                         done;
		logic [7:0]                   data_byte;
		logic [6:0]                   idx;
		logic [7:0]                   limit;
		logic [7:0]                   sent;
	} iqr_state_type;

	iqr_state_type st;
	iqr_state_type next_st;

	// ==========================================================
	// ASCII fields, cleaned and padded
	logic [ASCII_WORDS*32-1:0] ascii_raw;
	logic [ASCII_WORDS*32-1:0] ascii_clean;
	logic [6:0]                total_len;
	logic [7:0]                addl_len;

	assign ascii_raw = st.ascii;

	// Vendor 8, product 16, revision 4 bytes
	iqr_ascii_field #(.N(8)) u_vendor (
		.raw   (ascii_raw[63:0]),
		.clean (ascii_clean[63:0])
	);
	iqr_ascii_field #(.N(16)) u_product (
		.raw   (ascii_raw[191:64]),
		.clean (ascii_clean[191:64])
	);
	iqr_ascii_field #(.N(4)) u_revision (
		.raw   (ascii_raw[223:192]),
		.clean (ascii_clean[223:192])
	);

	// Response length: 36 mandatory plus vendor bytes, additional length counts after byte 4
	assign total_len = MANDATORY_LEN + {1'b0, st.extra};
	assign addl_len  = {1'b0, total_len - LEN_HDR};

	// ==========================================================
	// Response byte at a given offset
	function automatic logic [7:0] resp_byte(input logic [6:0] i, input logic [31:0] c0,
		input logic [31:0] c1, input logic [ASCII_WORDS*32-1:0] asc, input logic [7:0] al);
		logic [2:0] q;
		logic [4:0] t;
		logic [7:0] f;
		logic [2:0] nv;
		logic [7:0] b;
		q  = c0[F_QUAL +: 3];
		t  = c0[F_TYPE +: 5];
		f  = c1[F_FLAGS7 +: 8];
		nv = c1[F_NATVER +: 3];
		b  = 8'h00;
		if (t > TYPE_LAST_STD) begin
			t = TYPE_NONE;
		end
		if (q == QUAL_RSVD) begin
			q = QUAL_NO_LUN;
		end
		if (q == QUAL_NO_LUN) begin
			t = TYPE_NONE;
		end
		case (i)
			7'h00: begin
				if (c0[F_UNSUPP]) begin
					b = BYTE0_NO_LUN;
				end else begin
					b = {q, t};
				end
			end
			7'h01: b = {c1[F_REMOVABLE], c1[F_MODIFIER +: 7]};
			7'h02: begin
				if (nv > NATVER_MAX) begin
					nv = 3'h0;
				end
				b = {c1[F_INTLVER_A +: 2], c1[F_INTLVER_B +: 3], nv};
			end
			7'h03: begin
				// Async notify is reserved unless the type is a processor
				b = {c1[F_ASYNC_NTFY] && (t == TYPE_PROC) && !c0[F_UNSUPP],
					c1[F_TERM_MSG], 2'b00, RESP_FORMAT};
			end
			7'h04: b = al;
			7'h07: begin
				// Relative addressing implies linked commands
				b = {f[7:6], f[5], f[4], f[3] | f[7], 1'b0, f[1], f[0]};
			end
			default: begin
				if (i >= ASCII_FIRST && i < ASCII_END) begin
					b = asc[8*(i - ASCII_FIRST) +: 8];
				end else begin
					b = 8'h00;
				end
			end
		endcase
		return b;
	endfunction : resp_byte

	// Register read value
	function automatic logic [31:0] read_word(input iqr_state_type s, input logic [7:0] a,
		input logic [6:0] tl);
		logic [31:0] r;
		r = 32'h0;
		if (a == ADDR_CFG0) begin
			r = s.cfg0;
		end else if (a == ADDR_CFG1) begin
			r = s.cfg1;
		end else if (a == ADDR_VSLEN) begin
			r = {26'h0, s.extra};
		end else if (a == ADDR_STATUS) begin
			r = {9'h0, tl, s.sent, 7'h0, s.busy};
		end else if (a >= ADDR_ASCII0 && a <= ADDR_ASCII6) begin
			r = s.ascii[3'((a - ADDR_ASCII0) >> 2)];
		end
		return r;
	endfunction : read_word

	// True for a mapped register address
	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= ADDR_ASCII6);
	endfunction : addr_ok

	// ==========================================================
	// Next state
	always_comb begin
		logic [7:0] lim;
		logic [5:0] ex;
		lim     = 8'h00;
		ex      = 6'h00;
		next_st = st;
		next_st.done = 1'b0;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_got  = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			next_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_got  = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
			next_st.wready = 1'b0;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = addr_ok(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (st.aw_addr == ADDR_CFG0) begin
				next_st.cfg0 = merge_word(st.cfg0, st.w_data, st.w_strb, CFG0_MASK);
			end else if (st.aw_addr == ADDR_CFG1) begin
				next_st.cfg1 = merge_word(st.cfg1, st.w_data, st.w_strb, CFG1_MASK);
			end else if (st.aw_addr == ADDR_VSLEN && st.w_strb[0]) begin
				ex = st.w_data[5:0];
				next_st.extra = (ex > EXTRA_MAX) ? EXTRA_MAX : ex;
			end else if (st.aw_addr >= ADDR_ASCII0 && st.aw_addr <= ADDR_ASCII6
				&& st.aw_addr[1:0] == 2'b00) begin
				next_st.ascii[3'((st.aw_addr - ADDR_ASCII0) >> 2)] = merge_word(
					st.ascii[3'((st.aw_addr - ADDR_ASCII0) >> 2)], st.w_data, st.w_strb,
					32'hFFFF_FFFF);
			end
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid  = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready  = 1'b1;
		end

		// Read channel
		if (s_axi_arvalid && st.arready) begin
			next_st.arready = 1'b0;
			next_st.rvalid  = 1'b1;
			next_st.rdata   = read_word(st, s_axi_araddr, total_len);
			next_st.rresp   = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid  = 1'b0;
			next_st.arready = 1'b1;
		end

		// Response stream: bytes in ascending order up to the smaller length
		if (!st.busy) begin
			if (cmd_valid && st.cmd_ready) begin
				lim = ({1'b0, total_len} < cmd_alloc_len) ? {1'b0, total_len} : cmd_alloc_len;
				next_st.limit = lim;
				next_st.sent  = 8'h00;
				next_st.idx   = 7'h00;
				if (lim == 8'h00) begin
					next_st.done = 1'b1;
				end else begin
					next_st.busy       = 1'b1;
					next_st.cmd_ready  = 1'b0;
					next_st.data_valid = 1'b1;
					next_st.data_byte  = resp_byte(7'h00, st.cfg0, st.cfg1, ascii_clean,
						addl_len);
					next_st.data_last  = (lim == 8'h01);
				end
			end
		end else if (st.data_valid && data_ready) begin
			next_st.sent = st.sent + 8'h01;
			if (st.data_last) begin
				next_st.busy       = 1'b0;
				next_st.cmd_ready  = 1'b1;
				next_st.data_valid = 1'b0;
				next_st.data_last  = 1'b0;
				next_st.done       = 1'b1;
			end else begin
				next_st.idx       = st.idx + 7'h01;
				next_st.data_byte = resp_byte(st.idx + 7'h01, st.cfg0, st.cfg1, ascii_clean,
					addl_len);
				next_st.data_last = ({1'b0, st.idx} + 8'h02 == st.limit);
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st            <= '0;
			st.awready    <= 1'b1;
			st.wready     <= 1'b1;
			st.arready    <= 1'b1;
			st.cmd_ready  <= 1'b1;
			st.cfg0       <= CFG0_RESET;
			st.cfg1       <= CFG1_RESET;
			st.ascii      <= {ASCII_WORDS{ASCII_RESET}};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign cmd_ready     = st.cmd_ready;
	assign data_valid    = st.data_valid;
	assign data_byte     = st.data_byte;
	assign data_last     = st.data_last;
	assign cmd_done      = st.done;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_unsupported_byte0: assert property (data_valid && st.idx == 7'h00 && st.cfg0[F_UNSUPP]
		|-> data_byte == BYTE0_NO_LUN) else $error("byte zero not 7Fh for unsupported unit");
	a_qual_three_type: assert property (data_valid && st.idx == 7'h00 && data_byte[7:5] == QUAL_NO_LUN
		|-> data_byte[4:0] == TYPE_NONE) else $error("qualifier 011b without type 1Fh");
	a_no_rsvd_qual: assert property (data_valid && st.idx == 7'h00
		|-> data_byte[7:5] != QUAL_RSVD) else $error("reserved qualifier sent");
	a_format_two: assert property (data_valid && st.idx == 7'h03
		|-> data_byte[3:0] == RESP_FORMAT && data_byte[5:4] == 2'b00) else $error("bad format");
	a_notify_reserved: assert property (data_valid && st.idx == 7'h03
		&& st.cfg0[F_TYPE +: 5] != TYPE_PROC
		|-> !data_byte[7]) else $error("async notify set for non-processor");
	a_addl_length: assert property (data_valid && st.idx == 7'h04
		|-> data_byte == 8'(MANDATORY_LEN) + {2'b00, st.extra} - 8'(LEN_HDR))
		else $error("bad length");
	a_rel_linked: assert property (data_valid && st.idx == 7'h07 && data_byte[7]
		|-> data_byte[3]) else $error("relative addressing without linked");
	a_ascii_range: assert property (data_valid && st.idx >= ASCII_FIRST && st.idx < ASCII_END
		|-> is_graphic(data_byte)) else $error("non-graphic ASCII byte");
	a_ascending_order: assert property (data_valid && data_ready && !data_last
		|=> data_valid && st.idx == $past(st.idx) + 7'h01) else $error("byte order broken");
	a_stop_count: assert property (data_valid && data_ready && data_last
		|=> cmd_done && st.sent == st.limit && !data_valid) else $error("wrong byte count");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write response dropped");

	c_full_response: cover property (data_valid && data_last && st.idx == 7'h23);
	c_truncated: cover property (data_valid && data_last && st.idx == 7'h04);
	c_zero_alloc: cover property (cmd_done && !$past(data_valid));
	c_reg_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : iqr_builder
`default_nettype wire

// file: testbench/iqr_initiator.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Initiator model: issues one request and collects the bytes
module iqr_initiator (
	input  wire logic       core_clk,      // System clock
	output logic            cmd_valid,     // Request
	output logic [7:0]      cmd_alloc_len, // Allocation length
	input  wire logic       cmd_ready,     // Request taken
	input  wire logic       data_valid,    // Byte valid
	input  wire logic [7:0] data_byte,     // Byte
	input  wire logic       data_last,     // Final byte
	output logic            data_ready,    // Byte taken
	input  wire logic       cmd_done       // Transfer over
);
	logic [7:0] got [0:127];
	int         got_n;
	logic       fin;
	logic       last_seen;

	// Idle levels at time zero
	initial begin
		cmd_valid     = 1'b0;
		cmd_alloc_len = 8'hA5;
		data_ready    = 1'b0;
	end

	// One request; when slow is non-zero every slow-th cycle stalls
	task automatic fetch(input logic [7:0] len, input int slow);
		got_n = 0;
		fin = 1'b0;
		last_seen = 1'b0;
		cmd_alloc_len <= len;
		cmd_valid     <= 1'b1;
		do @(posedge core_clk); while (cmd_ready !== 1'b1);
		cmd_valid     <= 1'b0;
		cmd_alloc_len <= ~len; // A released line does not keep its value
		for (int c = 1; c < 400 && !fin; c++) begin
			data_ready <= (slow == 0) || (c % slow != 0);
			@(posedge core_clk);
			if (data_valid === 1'b1 && data_ready === 1'b1 && got_n < 128) begin
				got[got_n] = data_byte;
				got_n++;
				last_seen = data_last;
			end
			fin = (cmd_done === 1'b1);
		end
		data_ready <= 1'b0;
	endtask : fetch
endmodule : iqr_initiator
`default_nettype wire

// file: testbench/iqr_builder_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the identification response builder
module iqr_builder_bench;
	import iqr_pkg::*;
	logic        core_clk, rst_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, cmd_alloc_len, data_byte;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        cmd_valid, cmd_ready, data_valid, data_last, data_ready, cmd_done;
	int          errors, tests_run, cycles;
	logic [8:0]  c0_tab [8] = '{9'h100, 9'h000, 9'h029, 9'h040, 9'h065, 9'h00C, 9'h00B, 9'h082};
	logic [7:0]  b0_tab [8] = '{8'h7F, 8'h00, 8'h29, 8'h7F, 8'h7F, 8'h1F, 8'h0B, 8'h82};
	logic [7:0]  asc_tab [12] = '{8'h41, 8'h42, 8'h20, 8'h43, 8'h44, 8'h20, 8'h20, 8'h20,
		8'h50, 8'h51, 8'h52, 8'h53};

	iqr_builder uut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_alloc_len, .cmd_ready,
		.data_valid, .data_byte, .data_last, .data_ready, .cmd_done);
	iqr_initiator host (.core_clk, .cmd_valid, .cmd_alloc_len, .cmd_ready, .data_valid,
		.data_byte, .data_last, .data_ready, .cmd_done);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			final_report();
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// Compare one received byte
	task automatic chk_b(input int k, input logic [7:0] exp);
		check({24'h0, host.got[k]}, {24'h0, exp});
	endtask : chk_b

	// Bus write with expected response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge core_clk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr

	// Bus read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready  <= 1'b1;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		e = s_axi_rresp;
	endtask : rd

	// Verdict and end of run
	task automatic final_report();
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		errors = 0;
		tests_run = 0;
		cycles = 0;
		rst_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset values and refused addresses
		rd(ADDR_CFG0, v, r);
		check(v, CFG0_RESET);
		rd(ADDR_CFG1, v, r);
		check(v, CFG1_RESET);
		rd(ADDR_ASCII6, v, r);
		check(v, ASCII_RESET);
		rd(8'h2C, v, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h2C, 32'h0, RESP_SLVERR);
		wr(8'h02, 32'h0, RESP_SLVERR);
		// Default response at full length with stalls
		host.fetch(8'hFF, 3);
		check(32'(host.got_n), 32'(MANDATORY_LEN));
		chk_b(0, 8'h1F);
		chk_b(1, 8'h00);
		chk_b(2, 8'h02);
		chk_b(3, {4'h0, RESP_FORMAT});
		chk_b(4, 8'h1F);
		for (int k = 8; k < 36; k++) chk_b(k, ASCII_SPACE);
		// Qualifier and type table, one-byte transfers
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CFG0, {23'h0, c0_tab[i]}, RESP_OKAY);
			host.fetch(8'h01, 0);
			check(32'(host.got_n), 32'h1);
			check({31'h0, host.last_seen}, 32'h1);
			chk_b(0, b0_tab[i]);
		end
		// Capability flags set except linked, which relative addressing forces on, processor type
		wr(ADDR_CFG0, {27'h0, TYPE_PROC}, RESP_OKAY);
		wr(ADDR_CFG1, 32'hF703_992B, RESP_OKAY);
		rd(ADDR_CFG1, v, r);
		check(v, 32'hF303_992B);
		host.fetch(8'h08, 2);
		chk_b(1, 8'h95);
		chk_b(2, 8'h99);
		chk_b(3, 8'hC2);
		chk_b(7, 8'hFB);
		// Flags clear, reserved national version, notify bit on a non-processor
		wr(ADDR_CFG0, 32'h0, RESP_OKAY);
		wr(ADDR_CFG1, 32'h0001_0500, RESP_OKAY);
		host.fetch(8'h08, 0);
		chk_b(1, 8'h00);
		chk_b(2, 8'h00);
		chk_b(3, 8'h02);
		chk_b(7, 8'h00);
		// Text cleanup and vendor-specific tail
		wr(ADDR_ASCII0, 32'h437F_4241, RESP_OKAY);
		wr(ADDR_ASCII0 + 8'h04, 32'h4645_0044, RESP_OKAY);
		wr(ADDR_ASCII0 + 8'h08, 32'h5352_5150, RESP_OKAY);
		wr(ADDR_VSLEN, 32'd20, RESP_OKAY);
		host.fetch(8'hFF, 0);
		check(32'(host.got_n), 32'd56);
		chk_b(4, 8'h33);
		for (int k = 0; k < 12; k++) chk_b(k + 8, asc_tab[k]);
		for (int k = 36; k < 56; k++) chk_b(k, 8'h00);
		// Truncated transfer keeps the length byte
		host.fetch(8'h05, 0);
		check(32'(host.got_n), 32'd5);
		chk_b(4, 8'h33);
		// Longest tail, then an empty transfer
		wr(ADDR_VSLEN, 32'h3F, RESP_OKAY);
		host.fetch(8'hFF, 0);
		check(32'(host.got_n), 32'd96);
		chk_b(4, 8'h5B);
		host.fetch(8'h00, 0);
		check({31'h0, host.fin}, 32'h1);
		check(32'(host.got_n), 32'd0);
		// Status shows idle, nothing sent, full response size
		rd(ADDR_STATUS, v, r);
		check(v, 32'h0060_0000);
		final_report();
	end
endmodule : iqr_builder_bench
`default_nettype wire
